/* logic/bch_regs.svh */
// Register offsets, field positions and reset values of the block channel
`ifndef BCH_REGS_SVH
`define BCH_REGS_SVH

// Byte offsets on the register bus
`define BCH_OFS_FUNC     8'h00
`define BCH_OFS_FIRST    8'h04
`define BCH_OFS_LAST     8'h08
`define BCH_OFS_CURRENT  8'h0C
`define BCH_OFS_STATUS   8'h10
`define BCH_OFS_EQUIP    8'h14
`define BCH_OFS_DIRECT   8'h18
`define BCH_OFS_DIN      8'h1C

// Function register bits
`define BCH_FN_START_OUT 0
`define BCH_FN_START_IN  1
`define BCH_FN_TERMINATE 2
`define BCH_FN_END_SEL   3
`define BCH_FN_END_CLR   4
`define BCH_FN_DIR_IN    5

// Status word bits
`define BCH_ST_READY     0
`define BCH_ST_BUSY      1
`define BCH_ST_INT       2
`define BCH_ST_END       4
`define BCH_ST_REJECT    8
`define BCH_ST_REPLY     9

// Widths and reset values
`define BCH_ADDR_W       15
`define BCH_WORD_W       16
`define BCH_EQ_W         4
`define BCH_ADDR_RST     15'h0000
`define BCH_WORD_RST     16'h0000
`define BCH_EQ_RST       4'h0

`endif

/* logic/bch_pkg.sv */
// Types shared by the block channel modules
package bch_pkg;

    // Transfer sequencer states
    typedef enum logic [2:0] {
        BCH_IDLE,
        BCH_MEM_RD,
        BCH_EQ,
        BCH_MEM_WR,
        BCH_DIRECT
    } bch_state_type;

    // One request towards the equipment controller
    typedef struct packed {
        logic        write;
        logic [3:0]  equip;
        logic [15:0] data;
    } bch_eq_req_type;

    // One request towards core storage
    typedef struct packed {
        logic        we;
        logic [14:0] addr;
        logic [15:0] wdata;
    } bch_mem_req_type;

endpackage

/* logic/bch_apb_slave.sv */
// APB slave front end: decode, strobes and registered read data
`timescale 1ns/1ps
`include "bch_regs.svh"

module bch_apb_slave
    import bch_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic [31:0] rd_value,
    output logic             wr_strobe,
    output logic             rd_setup
);

    //------------------------------------------------------------
    // Decode
    //------------------------------------------------------------

    logic [31:0] prdata_reg;        // Read data captured at setup
    logic [31:0] prdata_next;       // Next read data
    logic        mapped;            // Address hits a register

    // True for any word-aligned register offset
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= `BCH_OFS_DIN);
    endfunction

    assign mapped    = is_mapped(paddr);
    // Zero wait states: every access ends at its first access cycle
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign wr_strobe = psel & penable & pwrite & mapped;
    assign rd_setup  = psel & ~penable & ~pwrite & mapped;
    assign prdata    = prdata_reg;

    // Read value sampled in the setup cycle, zero when unmapped
    always_comb
    begin
        prdata_next = prdata_reg;
        if (psel & ~penable & ~pwrite)
        begin
            prdata_next = mapped ? rd_value : 32'h00000000;
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            prdata_reg <= prdata_next;
        end
    end

endmodule

/* logic/bch_equip_port.sv */
// One handshake with the equipment controller: request held until reply, reject or abort
`timescale 1ns/1ps
`include "bch_regs.svh"

module bch_equip_port
    import bch_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            start,
    input  wire bch_eq_req_type  cmd,
    output logic                 eq_req,
    output bch_eq_req_type       eq_cmd,
    input  wire logic [15:0]     eq_rdata,
    input  wire logic            eq_reply,
    input  wire logic            eq_reject,
    input  wire logic            abort,
    output logic                 done,
    output logic                 rejected,
    output logic [15:0]          rdata
);

    //------------------------------------------------------------
    // Request holder
    //------------------------------------------------------------

    logic           req_reg;        // Request outstanding
    logic           req_next;
    bch_eq_req_type cmd_reg;        // Request held on the pins
    bch_eq_req_type cmd_next;

    assign eq_req   = req_reg;
    assign eq_cmd   = cmd_reg;
    // Answer seen at this edge; equipment data passes straight on
    assign done     = req_reg & (eq_reply | eq_reject);
    assign rejected = req_reg & eq_reject & ~eq_reply;
    assign rdata    = eq_rdata;

    // Hold the request until an answer or an abort; absent equipment hangs it
    always_comb
    begin
        req_next = req_reg;
        cmd_next = cmd_reg;
        if (abort || done)
        begin
            req_next = 1'b0;
        end
        else if (start && !req_reg)
        begin
            req_next = 1'b1;
            cmd_next = cmd;
        end
    end

    // Request registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_reg <= 1'b0;
            cmd_reg <= '0;
        end
        else
        begin
            req_reg <= req_next;
            cmd_reg <= cmd_next;
        end
    end

endmodule

/* logic/bch_block_channel.sv */
// Block channel: buffered word transfers between core storage and equipment
`timescale 1ns/1ps
`include "bch_regs.svh"

module bch_block_channel
    import bch_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    output logic             mem_req,
    output bch_mem_req_type  mem_cmd,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic             eq_req,
    output bch_eq_req_type   eq_cmd,
    input  wire logic [15:0] eq_rdata,
    input  wire logic        eq_reply,
    input  wire logic        eq_reject,
    output logic             end_of_operation_int
);

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------

    bch_state_type   state_reg;     // Sequencer state
    bch_state_type   state_next;
    logic [14:0]     first_reg;     // First word address minus one
    logic [14:0]     first_next;
    logic [14:0]     last_reg;      // Last word address
    logic [14:0]     last_next;
    logic [14:0]     current_word_address_reg;  // Current word address
    logic [14:0]     current_word_address_next;
    logic [3:0]      equip_reg;     // Selected equipment
    logic [3:0]      equip_next;
    logic            out_reg;       // Transfer direction, storage to equipment
    logic            out_next;
    logic [15:0]     word_reg;      // Word in flight or direct input data
    logic [15:0]     word_next;
    logic            end_of_operation_reg;      // End of operation indicator
    logic            end_of_operation_next;
    logic            sel_reg;       // End-of-operation interrupt selected
    logic            sel_next;
    logic            int_reg;       // Interrupt indicator
    logic            int_next;
    logic            reply_reg;     // Reply indicator
    logic            reply_next;
    logic            rej_reg;       // Last direct access refused
    logic            rej_next;
    logic            mreq_reg;      // Storage request outstanding
    logic            mreq_next;
    bch_mem_req_type mcmd_reg;      // Storage request held
    bch_mem_req_type mcmd_next;
    logic            eq_start;      // Launch an equipment handshake
    bch_eq_req_type  eq_launch;     // Equipment request to launch
    logic            eq_done;       // Equipment answered
    logic            eq_rejected;   // Equipment answered with reject
    logic [15:0]     eq_word;       // Equipment data at the answer
    logic            eq_abort;      // Drop a hung handshake
    logic            wr_strobe;     // Register write takes effect
    logic            rd_setup;      // Register read setup, tied low; the slave's rd_setup output is left unconnected
    logic [31:0]     rd_value;      // Read multiplexer
    logic [15:0]     status_word;   // Channel status word
    logic            busy;          // Buffered transfer in progress
    logic            fn_wr;         // Function register written
    logic            dir_wr;        // Direct output register written

    // Address that ends a transfer: last plus one, wrapping in 15 bits
    function automatic logic [14:0] end_addr(input logic [14:0] last);
        end_addr = 15'(last + 15'h0001);
    endfunction

    // Next address after one word, wrapping in 15 bits
    function automatic logic [14:0] step_addr(input logic [14:0] a);
        step_addr = 15'(a + 15'h0001);
    endfunction

    //------------------------------------------------------------
    // Bus front end and equipment handshake
    //------------------------------------------------------------

    bch_apb_slave u_apb (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pready    (pready),
        .pslverr   (pslverr),
        .prdata    (prdata),
        .rd_value  (rd_value),
        .wr_strobe (wr_strobe),
        .rd_setup  ()
    );

    bch_equip_port u_eq (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (eq_start),
        .cmd       (eq_launch),
        .eq_req    (eq_req),
        .eq_cmd    (eq_cmd),
        .eq_rdata  (eq_rdata),
        .eq_reply  (eq_reply),
        .eq_reject (eq_reject),
        .abort     (eq_abort),
        .done      (eq_done),
        .rejected  (eq_rejected),
        .rdata     (eq_word)
    );

    assign rd_setup = 1'b0;
    assign fn_wr    = wr_strobe && (paddr == `BCH_OFS_FUNC);
    assign dir_wr   = wr_strobe && (paddr == `BCH_OFS_DIRECT);
    assign busy     = (state_reg == BCH_MEM_RD) || (state_reg == BCH_EQ)
                   || (state_reg == BCH_MEM_WR);
    assign mem_req  = mreq_reg;
    assign mem_cmd  = mcmd_reg;
    assign end_of_operation_int = int_reg;
    // Terminate drops any handshake that equipment never answers
    assign eq_abort = fn_wr && pwdata[`BCH_FN_TERMINATE];

    //------------------------------------------------------------
    // Status word and read multiplexer
    //------------------------------------------------------------

    // Assemble the status word; unlisted bits read zero
    always_comb
    begin
        status_word = 16'h0000;
        status_word[`BCH_ST_READY]  = (state_reg == BCH_IDLE);
        status_word[`BCH_ST_BUSY]   = busy;
        status_word[`BCH_ST_INT]    = int_reg;
        // End of operation at bit 4
        status_word[`BCH_ST_END]    = end_of_operation_reg;
        status_word[`BCH_ST_REJECT] = busy | rej_reg;
        status_word[`BCH_ST_REPLY]  = reply_reg;
    end

    // Register read values, 16-bit or narrower in the low bits
    always_comb
    begin
        rd_value = 32'h00000000;
        unique case (paddr)
            `BCH_OFS_FIRST:   rd_value = {17'h00000, first_reg};
            `BCH_OFS_LAST:    rd_value = {17'h00000, last_reg};
            `BCH_OFS_CURRENT: rd_value = {17'h00000, current_word_address_reg};
            `BCH_OFS_STATUS:  rd_value = {16'h0000, status_word};
            `BCH_OFS_EQUIP:   rd_value = {28'h0000000, equip_reg};
            `BCH_OFS_DIN:     rd_value = {16'h0000, word_reg};
            default:          rd_value = 32'h00000000;
        endcase
    end

    //------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------

    // Next values of sequencer, address and indicator registers
    always_comb
    begin
        state_next = state_reg;
        first_next = first_reg;
        last_next  = last_reg;
        current_word_address_next = current_word_address_reg;
        equip_next = equip_reg;
        out_next   = out_reg;
        word_next  = word_reg;
        end_of_operation_next = end_of_operation_reg;
        sel_next   = sel_reg;
        int_next   = int_reg;
        reply_next = reply_reg;
        rej_next   = rej_reg;
        mreq_next  = mreq_reg;
        mcmd_next  = mcmd_reg;
        eq_start   = 1'b0;
        eq_launch  = '{write: out_reg, equip: equip_reg, data: word_reg};

        // Address and equipment registers written while idle only
        if (wr_strobe && state_reg == BCH_IDLE)
        begin
            if (paddr == `BCH_OFS_FIRST) first_next = pwdata[14:0];
            if (paddr == `BCH_OFS_LAST)  last_next  = pwdata[14:0];
            if (paddr == `BCH_OFS_EQUIP) equip_next = pwdata[3:0];
        end

        if (fn_wr && pwdata[`BCH_FN_END_SEL])
        begin
            sel_next = 1'b1;
        end
        if (fn_wr && pwdata[`BCH_FN_END_CLR])
        begin
            sel_next = 1'b0;
            int_next = 1'b0;
        end

        unique case (state_reg)
            BCH_IDLE:
            begin
                if (fn_wr && (pwdata[`BCH_FN_START_OUT] || pwdata[`BCH_FN_START_IN]))
                begin
                    current_word_address_next = step_addr(first_reg);
                    out_next   = pwdata[`BCH_FN_START_OUT];
                    reply_next = 1'b1;
                    rej_next   = 1'b0;
                    end_of_operation_next = 1'b0;
                    if (step_addr(first_reg) == end_addr(last_reg))
                    begin
                        // Empty buffer completes at once
                        end_of_operation_next = 1'b1;
                        int_next = sel_reg | int_next;
                    end
                    else if (pwdata[`BCH_FN_START_OUT])
                    begin
                        state_next = BCH_MEM_RD;
                        mreq_next  = 1'b1;
                        mcmd_next  = '{we: 1'b0, addr: step_addr(first_reg),
                                       wdata: `BCH_WORD_RST};
                    end
                    else
                    begin
                        state_next = BCH_EQ;
                        eq_start   = 1'b1;
                        eq_launch  = '{write: 1'b0, equip: equip_reg, data: word_reg};
                    end
                end
                else if (dir_wr || (fn_wr && pwdata[`BCH_FN_DIR_IN]))
                begin
                    state_next = BCH_DIRECT;
                    eq_start   = 1'b1;
                    eq_launch  = '{write: dir_wr, equip: equip_reg, data: pwdata[15:0]};
                end
            end
            BCH_MEM_RD:
            begin
                // Word fetched from storage goes to equipment
                if (mem_ack)
                begin
                    mreq_next  = 1'b0;
                    word_next  = mem_rdata;
                    state_next = BCH_EQ;
                    eq_start   = 1'b1;
                    eq_launch  = '{write: 1'b1, equip: equip_reg, data: mem_rdata};
                end
            end
            BCH_EQ:
            begin
                if (!eq_req || (eq_done && eq_rejected))
                begin
                    // Refused request drops one cycle, then is raised again
                    eq_start  = 1'b1;
                end
                else if (eq_done && out_reg)
                begin
                    current_word_address_next = step_addr(current_word_address_reg);
                    if (step_addr(current_word_address_reg) == end_addr(last_reg))
                    begin
                        state_next = BCH_IDLE;
                        end_of_operation_next = 1'b1;
                        int_next   = sel_reg | int_next;
                    end
                    else
                    begin
                        state_next = BCH_MEM_RD;
                        mreq_next  = 1'b1;
                        mcmd_next  = '{we: 1'b0, addr: step_addr(current_word_address_reg),
                                       wdata: `BCH_WORD_RST};
                    end
                end
                else if (eq_done)
                begin
                    // Same data path as direct input
                    word_next  = eq_word;
                    state_next = BCH_MEM_WR;
                    mreq_next  = 1'b1;
                    mcmd_next  = '{we: 1'b1, addr: current_word_address_reg, wdata: eq_word};
                end
            end
            BCH_MEM_WR:
            begin
                if (mem_ack)
                begin
                    mreq_next = 1'b0;
                    current_word_address_next = step_addr(current_word_address_reg);
                    if (step_addr(current_word_address_reg) == end_addr(last_reg))
                    begin
                        state_next = BCH_IDLE;
                        end_of_operation_next = 1'b1;
                        int_next   = sel_reg | int_next;
                    end
                    else
                    begin
                        state_next = BCH_EQ;
                        eq_start   = 1'b1;
                        eq_launch  = '{write: 1'b0, equip: equip_reg, data: word_reg};
                    end
                end
            end
            BCH_DIRECT:
            begin
                if (eq_done)
                begin
                    state_next = BCH_IDLE;
                    reply_next = ~eq_rejected;
                    rej_next   = eq_rejected;
                    if (!eq_cmd.write) word_next = eq_word;
                end
            end
            default:
            begin
                state_next = BCH_IDLE;
            end
        endcase

        if (busy && (dir_wr || (fn_wr && pwdata[`BCH_FN_DIR_IN])))
        begin
            rej_next = 1'b1;
        end

        // Terminate stops any transfer or hung direct access
        if (eq_abort && state_reg != BCH_IDLE)
        begin
            state_next = BCH_IDLE;
            mreq_next  = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= BCH_IDLE;
            first_reg <= `BCH_ADDR_RST;
            last_reg  <= `BCH_ADDR_RST;
            current_word_address_reg <= `BCH_ADDR_RST;
            equip_reg <= `BCH_EQ_RST;
            out_reg   <= 1'b0;
            word_reg  <= `BCH_WORD_RST;
            end_of_operation_reg <= 1'b0;
            sel_reg   <= 1'b0;
            int_reg   <= 1'b0;
            reply_reg <= 1'b0;
            rej_reg   <= 1'b0;
            mreq_reg  <= 1'b0;
            mcmd_reg  <= '0;
        end
        else
        begin
            state_reg <= state_next;
            first_reg <= first_next;
            last_reg  <= last_next;
            current_word_address_reg <= current_word_address_next;
            equip_reg <= equip_next;
            out_reg   <= out_next;
            word_reg  <= word_next;
            end_of_operation_reg <= end_of_operation_next;
            sel_reg   <= sel_next;
            int_reg   <= int_next;
            reply_reg <= reply_next;
            rej_reg   <= rej_next;
            mreq_reg  <= mreq_next;
            mcmd_reg  <= mcmd_next;
        end
    end

endmodule

/* verification/bch_block_channel_assertions.sv */
// Port checker of the block channel
`timescale 1ns/1ps
module bch_block_channel_assertions
    import bch_pkg::*;
(
    input wire logic             pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata, prdata,
    input wire logic             mem_req, mem_ack, eq_req, eq_reply, eq_reject, end_of_operation_int,
    input wire logic [15:0]      mem_rdata, eq_rdata,
    input wire bch_mem_req_type  mem_cmd,
    input wire bch_eq_req_type   eq_cmd
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("bus waited");
    a_address_read: assert property (psel && penable && paddr == 8'h0C |-> !pslverr)
        else $error("address read refused");
    a_func_ok: assert property (psel && penable && paddr == 8'h00 |-> !pslverr)
        else $error("function refused");
    a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
        else $error("storage request moved");
    a_out_word: assert property (mem_req && mem_ack && !mem_cmd.we |=>
        eq_req && eq_cmd.write && eq_cmd.data == $past(mem_rdata)) else $error("word lost");
    a_one_side: assert property (!(mem_req && eq_req))
        else $error("two requests at once");
    a_eq_hold: assert property (eq_req && !eq_reply && !eq_reject && !(psel && pwrite)
        |=> eq_req && $stable(eq_cmd)) else $error("equipment request moved");
    a_int_cause: assert property ($rose(end_of_operation_int)
        |-> $past(eq_reply || mem_ack || pwrite)) else $error("interrupt without end");
    a_int_clear: assert property ($fell(end_of_operation_int)
        |-> $past(psel && pwrite && paddr == 8'h00 && pwdata[4])) else $error("interrupt lost");
endmodule
bind bch_block_channel bch_block_channel_assertions bch_block_channel_assertions_inst (.*);

/* verification/bch_far_model.sv */
// Behavioural core storage and equipment controller at the channel's far side
`timescale 1ns/1ps
module bch_far_model
    import bch_pkg::*;
(
    input wire logic             pclk, mem_req, eq_req, absent, slow,
    input wire bch_mem_req_type  mem_cmd,
    input wire bch_eq_req_type   eq_cmd,
    output logic                 mem_ack, eq_reply, eq_reject,
    output logic [15:0]          mem_rdata, eq_rdata
);
    logic [15:0] mem [32768]; // Core storage, preset to address xor A500
    logic [15:0] last_word;   // Last word the equipment took
    logic        ph;          // Slow mode refuses or answers on alternate cycles
    // Released data lines show the inverse word
    assign mem_rdata = mem_ack ? mem[mem_cmd.addr] : ~mem[mem_cmd.addr];
    assign eq_rdata = eq_reply ? 16'h3C5A : 16'hC3A5;
    initial
    begin
        {ph, mem_ack, eq_reply, eq_reject, last_word} = '0;
        for (int i = 0; i < 32768; i++) mem[i] = 16'(i) ^ 16'hA500;
    end
    always @(posedge pclk)
    begin
        ph <= !ph;
        mem_ack <= mem_req && !mem_ack && (!slow || ph);
        eq_reply <= eq_req && !eq_reply && !eq_reject && !absent && (!slow || ph);
        eq_reject <= eq_req && !eq_reply && !eq_reject && !absent && slow && !ph;
        if (mem_ack && mem_cmd.we) mem[mem_cmd.addr] <= mem_cmd.wdata;
        if (eq_reply && eq_cmd.write) last_word <= eq_cmd.data;
    end
endmodule

/* verification/bch_block_channel_bench.sv */
// Self-checking bench of the block channel
`timescale 1ns/1ps
module bch_block_channel_bench;
    import bch_pkg::*;
    typedef struct packed {logic [14:0] first, last, fin; logic dir, slow;} bch_row_type;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, absent = 0, slow = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, mem_req, mem_ack, eq_req, eq_reply, eq_reject;
    logic end_of_operation_int;
    logic [15:0] mem_rdata, eq_rdata;
    bch_mem_req_type mem_cmd;
    bch_eq_req_type eq_cmd;
    int n_fail = 0, n_checks = 0;
    // Rows: first minus one, last, final address, input, slow far side
    bch_row_type rows [3] = '{'{15'h0009, 15'h000A, 15'h000B, 1'b0, 1'b0},
        '{15'h7FFC, 15'h7FFF, 15'h0000, 1'b0, 1'b1}, '{15'h0064, 15'h0067, 15'h0068, 1'b1, 1'b1}};
    bch_block_channel bch_block_channel_inst (.*);
    bch_far_model bch_far_model_inst (.*);
    initial forever #12.5 pclk = ~pclk;
    task automatic chk(input string nm, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 400; k++)
        begin
            bus(0, 8'h10, 0);
            if (q[0] === 1'b1) break;
        end
    endtask
    task automatic complete_run;
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #1000000;
        n_fail++;
        complete_run;
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        bus(0, 8'h10, 0);
        chk("status", 32'h1, q);
        bus(0, 8'h20, 0);
        chk("unmapped", 32'h1, {31'h0, err});
        foreach (rows[i])
        begin
            slow <= rows[i].slow;
            bus(1, 8'h00, 32'h8);
            bus(1, 8'h04, {17'h0, rows[i].first});
            bus(1, 8'h08, {17'h0, rows[i].last});
            bus(1, 8'h00, rows[i].dir ? 32'h2 : 32'h1);
            bus(0, 8'h10, 0);
            chk("status", 32'h302, q);
            wait_idle;
            chk("status", 32'h215, q);
            chk("interrupt", 32'h1, {31'h0, end_of_operation_int});
            bus(0, 8'h0C, 0);
            chk("address", {17'h0, rows[i].fin}, q);
            chk("word", rows[i].dir ? 32'h3C5A : {17'h0, rows[i].last} ^ 32'hA500,
                rows[i].dir ? bch_far_model_inst.mem[rows[i].last]
                : bch_far_model_inst.last_word);
            bus(1, 8'h00, 32'h10);
            chk("interrupt", 32'h0, {31'h0, end_of_operation_int});
        end
        slow <= 0;
        bus(1, 8'h18, 32'h0000BEEF);
        wait_idle;
        chk("direct", 32'hBEEF, {16'h0, bch_far_model_inst.last_word});
        chk("status", 32'h211, q);
        bus(1, 8'h00, 32'h20);
        wait_idle;
        bus(0, 8'h1C, 0);
        chk("direct in", 32'h3C5A, q);
        absent <= 1;
        bus(1, 8'h04, 32'h7FFF);
        bus(1, 8'h08, 32'h0005);
        bus(1, 8'h00, 32'h1);
        repeat (20) @(posedge pclk);
        bus(0, 8'h0C, 0);
        chk("address", 32'h0, q);
        bus(0, 8'h10, 0);
        chk("status", 32'h302, q);
        bus(1, 8'h00, 32'h4);
        absent <= 0;
        bus(0, 8'h10, 0);
        chk("status", 32'h201, q);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        bus(0, 8'h10, 0);
        chk("status", 32'h1, q);
        complete_run;
    end
endmodule
